/* File: design/fsm_fault_shutdown_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module fsm_fault_shutdown_monitor #(
    parameter int GROUND_LOSS_FILTER_CYCLES = fsm_pkg::GROUND_LOSS_FILTER_CYCLES,
    parameter int DIGITAL_READY_CYCLES = fsm_pkg::DIGITAL_READY_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // analog monitor flags
    input wire logic groundLost,
    input wire logic overTemp,
    input wire logic logicSupplyUndervoltage,
    input wire logic highRailUndervoltage,
    input wire logic supplyOvervoltage,
    input wire logic clockMonitorEnable,
    // pins and channel commands
    input wire logic driverEnable,
    input wire logic [fsm_pkg::NUM_HIGH_SIDE-1:0] hsIn,
    // register access port
    input wire logic [9:0] regAddr,
    input wire logic regWrEn,
    input wire logic [15:0] regWrData,
    input wire logic regRdEn,
    output logic [15:0] regRdData,
    output logic regRdValid,
    // protection outputs
    output logic gateSupplyUndervoltage,
    output logic [fsm_pkg::NUM_HIGH_SIDE-1:0] hsCommand,
    output logic deviceOff,
    output logic interruptRequest_n,
    output logic digitalReady
);
    logic [19:0] gndCnt_q;
    logic gateUv_q;
    logic overheat_q;
    logic [15:0] config_q;
    logic [16:0] readyCnt_q;
    logic ready_q;
    logic [15:0] rdData_q;
    logic rdValid_q;
    logic [fsm_pkg::NUM_HIGH_SIDE-1:0] hsCmd_q;
    logic deviceOff_q;
    logic statusRead;
    logic drvPermit;
    logic [15:0] statusWord;

    assign statusRead = regRdEn && (regAddr == fsm_pkg::DRIVER_FAULT_STATUS_ADDR);

    // ground loss filter: persistent loss only
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gndCnt_q <= 20'h00000;
            gateUv_q <= 1'b0;
        end else if (!groundLost) begin
            gndCnt_q <= 20'h00000;
            gateUv_q <= 1'b0;
        end else if (gndCnt_q == 20'(GROUND_LOSS_FILTER_CYCLES - 1)) begin
            gateUv_q <= 1'b1;
        end else begin
            gndCnt_q <= gndCnt_q + 20'h00001;
        end
    end

    // sticky overheat, set wins over read clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            overheat_q <= 1'b0;
        end else if (overTemp) begin
            overheat_q <= 1'b1;
        end else if (statusRead) begin
            overheat_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            config_q <= fsm_pkg::DRIVER_CONFIGURATION_RST;
        end else if (regWrEn && regAddr == fsm_pkg::DRIVER_CONFIGURATION_ADDR) begin
            config_q <= regWrData;
        end
    end

    // status snapshot: sticky overheat, filtered gate UV, live enable and supply flags
    always_comb begin
        statusWord = 16'h0000;
        statusWord[fsm_pkg::STS_OVERHEAT_BIT] = overheat_q | overTemp;
        statusWord[fsm_pkg::STS_DRIVER_ENABLE_BIT] = driverEnable;
        statusWord[fsm_pkg::STS_GATE_UV_BIT] = gateUv_q;
        statusWord[fsm_pkg::STS_LOGIC_UV_BIT] = logicSupplyUndervoltage;
        statusWord[fsm_pkg::STS_HIGH_RAIL_UV_BIT] = highRailUndervoltage;
    end

    // read path keeps working with drivers off
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_q <= 16'h0000;
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= regRdEn;
            if (!regRdEn) begin
                rdData_q <= rdData_q;
            end else if (regAddr == fsm_pkg::DRIVER_FAULT_STATUS_ADDR) begin
                rdData_q <= statusWord;
            end else if (regAddr == fsm_pkg::DRIVER_CONFIGURATION_ADDR) begin
                rdData_q <= config_q;
            end else begin
                rdData_q <= 16'h0000;
            end
        end
    end

    // digital ready delay after reset release
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            readyCnt_q <= 17'h00000;
            ready_q <= 1'b0;
        end else if (readyCnt_q == 17'(DIGITAL_READY_CYCLES - 1)) begin
            ready_q <= 1'b1;
        end else begin
            readyCnt_q <= readyCnt_q + 17'h00001;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            deviceOff_q <= 1'b1;
        end else begin
            deviceOff_q <= supplyOvervoltage;
        end
    end

    assign drvPermit = driverEnable && !gateUv_q && !logicSupplyUndervoltage
        && !highRailUndervoltage && clockMonitorEnable && !supplyOvervoltage;

    generate
        for (genvar ch = 0; ch < fsm_pkg::NUM_HIGH_SIDE; ch++) begin : g_hs
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    hsCmd_q[ch] <= 1'b0;
                end else begin
                    hsCmd_q[ch] <= drvPermit && hsIn[ch];
                end
            end
        end
    endgenerate

    // interrupt follows overheat without waiting a cycle
    assign interruptRequest_n = !(ready_q && !deviceOff_q &&
        config_q[fsm_pkg::CFG_OVERHEAT_IRQ_EN_BIT] && (overheat_q || overTemp));

    assign regRdData = rdData_q;
    assign regRdValid = rdValid_q;
    assign gateSupplyUndervoltage = gateUv_q;
    assign hsCommand = hsCmd_q;
    assign deviceOff = deviceOff_q;
    assign digitalReady = ready_q;

    // checks
    gnd_filter_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(gateSupplyUndervoltage) |->
            $past(gndCnt_q) == 20'(GROUND_LOSS_FILTER_CYCLES - 1) && $past(groundLost))
        else $error("gate undervoltage rose without full filter time");
    gnd_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !groundLost |=> !gateSupplyUndervoltage)
        else $error("gate undervoltage held without ground loss");
    uv_drv_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
        gateSupplyUndervoltage |=> hsCommand == '0)
        else $error("driver on during gate undervoltage");
    overheat_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
        overTemp |=> overheat_q)
        else $error("overheat not latched");
    overheat_bit_a: assert property (@(posedge mclk) disable iff (!rst_b)
        regRdEn && regAddr == fsm_pkg::DRIVER_FAULT_STATUS_ADDR && overTemp
            |=> regRdValid && regRdData[fsm_pkg::STS_OVERHEAT_BIT])
        else $error("overheat not reported in status");
    overheat_irq_a: assert property (@(posedge mclk) disable iff (!rst_b)
        overTemp && config_q[fsm_pkg::CFG_OVERHEAT_IRQ_EN_BIT] && ready_q && !deviceOff_q
            |-> !interruptRequest_n)
        else $error("interrupt not raised on overheat");
    enable_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !driverEnable |=> hsCommand == '0)
        else $error("driver on while enable low");
    enable_bit_a: assert property (@(posedge mclk) disable iff (!rst_b)
        regRdEn && regAddr == fsm_pkg::DRIVER_FAULT_STATUS_ADDR
            |=> regRdData[fsm_pkg::STS_DRIVER_ENABLE_BIT] == $past(driverEnable))
        else $error("enable level misreported");
    overvolt_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
        supplyOvervoltage |=> deviceOff && hsCommand == '0)
        else $error("overvoltage did not shut off");
    ready_time_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(digitalReady) |-> $past(readyCnt_q) == 17'(DIGITAL_READY_CYCLES - 1))
        else $error("ready at wrong time");
    cmd_on_a: assert property (@(posedge mclk) disable iff (!rst_b)
        drvPermit && hsIn[0] |=> hsCommand[0])
        else $error("command off with all permits");
    sticky_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        overheat_q && !statusRead |=> overheat_q)
        else $error("overheat cleared without read");
    irq_mask_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !config_q[fsm_pkg::CFG_OVERHEAT_IRQ_EN_BIT] || !(overheat_q || overTemp) |-> interruptRequest_n)
        else $error("interrupt raised while masked or idle");
    perm_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !drvPermit |=> hsCommand == '0)
        else $error("command on without every permit");
    overvolt_end_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !supplyOvervoltage |=> !deviceOff)
        else $error("device held off after overvoltage cleared");
    cfg_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
        regWrEn && regAddr == fsm_pkg::DRIVER_CONFIGURATION_ADDR |=> config_q == $past(regWrData))
        else $error("configuration write lost");
    rd_answer_a: assert property (@(posedge mclk) disable iff (!rst_b)
        regRdEn |=> regRdValid)
        else $error("read not answered");

    gnd_trip_c: cover property (@(posedge mclk) disable iff (!rst_b)
        $rose(gateSupplyUndervoltage));
    irq_c: cover property (@(posedge mclk) disable iff (!rst_b) $fell(interruptRequest_n));
    clear_c: cover property (@(posedge mclk) disable iff (!rst_b)
        overheat_q && statusRead && !overTemp ##1 !overheat_q);
    drive_c: cover property (@(posedge mclk) disable iff (!rst_b) hsCommand != '0);
    overvolt_c: cover property (@(posedge mclk) disable iff (!rst_b) $rose(deviceOff));
endmodule
`default_nettype wire

/* File: design/fsm_pkg.sv */
// Function
// - detect loss of any ground pins
// - ground loss raises gate-supply undervoltage, drivers off
// - ground loss filtered about 1.3 ms
// - temperature trip sets overheat signal
// - overheat bit readable in status register
// - enabled overheat raises interrupt immediately
// - enable low holds drivers off, core runs
// - enable pin level readable in status
// - supply overvoltage sets device off and forces drivers and interrupt off, register reads still work
// - digital outputs ready within 300 us
// - high-side command needs all permits high
`default_nettype none
package fsm_pkg;
    // register offsets
    localparam logic [9:0] DRIVER_CONFIGURATION_ADDR = 10'h1C5;
    localparam logic [9:0] DRIVER_FAULT_STATUS_ADDR = 10'h1D2;
    // reset values
    localparam logic [15:0] DRIVER_CONFIGURATION_RST = 16'h0000;
    // configuration fields
    localparam int CFG_OVERHEAT_IRQ_EN_BIT = 0;
    // status fields
    localparam int STS_OVERHEAT_BIT = 0;
    localparam int STS_DRIVER_ENABLE_BIT = 1;
    localparam int STS_GATE_UV_BIT = 2;
    localparam int STS_LOGIC_UV_BIT = 3;
    localparam int STS_HIGH_RAIL_UV_BIT = 4;
    // timing
    localparam int CLK_PERIOD_PS = 4000;
    // filter time in tenths of a millisecond, one tenth is 100000000 ps
    localparam int GROUND_LOSS_FILTER_TIME_MS_X10 = 13;
    localparam int GROUND_LOSS_FILTER_CYCLES =
        (GROUND_LOSS_FILTER_TIME_MS_X10 * 100000000) / CLK_PERIOD_PS;
    localparam int DIGITAL_READY_DELAY_US = 300;
    localparam int DIGITAL_READY_CYCLES = (DIGITAL_READY_DELAY_US * 1000000) / CLK_PERIOD_PS;
    localparam int NUM_HIGH_SIDE = 5;
endpackage
`default_nettype wire

/* File: test/fsm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fsm_host_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // fault interrupt and re-enable request
    input wire logic interruptRequest_n,
    input wire logic rearm,
    // enable pin
    output logic driverEnable
);
    // pin drops on any fault interrupt, rises again only on request
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            driverEnable <= 1'b1;
        end else if (!interruptRequest_n) begin
            driverEnable <= 1'b0;
        end else if (rearm) begin
            driverEnable <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: test/fsm_fault_shutdown_monitor_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module fsm_fault_shutdown_monitor_bench;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic groundLost = 1'b0, overTemp = 1'b0, logicSupplyUndervoltage = 1'b0;
    logic highRailUndervoltage = 1'b0, supplyOvervoltage = 1'b0, clockMonitorEnable = 1'b1;
    logic regWrEn = 1'b0, regRdEn = 1'b0, rearm = 1'b0;
    logic [fsm_pkg::NUM_HIGH_SIDE-1:0] hsIn = 5'h00;
    logic [9:0] regAddr = 10'h000;
    logic [15:0] regWrData = 16'h0000;
    logic [15:0] rd;
    wire logic driverEnable, gateSupplyUndervoltage, deviceOff, interruptRequest_n;
    wire logic digitalReady, regRdValid;
    wire logic [15:0] regRdData;
    wire logic [fsm_pkg::NUM_HIGH_SIDE-1:0] hsCommand;
    int mismatches = 0;
    int comparisons = 0;

    fsm_fault_shutdown_monitor #(.GROUND_LOSS_FILTER_CYCLES(8), .DIGITAL_READY_CYCLES(4))
        u_fsm_fault_shutdown_monitor (.mclk, .rst_b, .groundLost, .overTemp,
        .logicSupplyUndervoltage, .highRailUndervoltage, .supplyOvervoltage,
        .clockMonitorEnable, .driverEnable, .hsIn, .regAddr, .regWrEn, .regWrData, .regRdEn,
        .regRdData, .regRdValid, .gateSupplyUndervoltage, .hsCommand, .deviceOff,
        .interruptRequest_n, .digitalReady);
    fsm_host_model u_fsm_host_model (.mclk, .rst_b, .interruptRequest_n, .rearm, .driverEnable);

    initial begin
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd_reg(input logic [9:0] a, output logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        #1;
        chk(16'(regRdValid), 16'h0001);
        d = regRdData;
    endtask
    task automatic set_block(input int k, input logic v);
        @(posedge mclk);
        case (k)
            0: logicSupplyUndervoltage <= v;
            1: highRailUndervoltage <= v;
            2: clockMonitorEnable <= !v;
            default: supplyOvervoltage <= v;
        endcase
        wait_cyc(2);
    endtask
    task automatic print_verdict;
        $display("counts: comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        chk(16'(digitalReady), 16'h0000);
        chk(16'(deviceOff), 16'h0001);
        rst_b <= 1'b1;
        wait_cyc(3);
        chk(16'(digitalReady), 16'h0000);
        wait_cyc(1);
        chk(16'(digitalReady), 16'h0001);
        rd_reg(fsm_pkg::DRIVER_CONFIGURATION_ADDR, rd);
        chk(rd, fsm_pkg::DRIVER_CONFIGURATION_RST);
        rd_reg(10'h3FF, rd);
        chk(rd, 16'h0000);
        wr(fsm_pkg::DRIVER_CONFIGURATION_ADDR, 16'hA5A5);
        rd_reg(fsm_pkg::DRIVER_CONFIGURATION_ADDR, rd);
        chk(rd, 16'hA5A5);
        $display("test registers done");
        @(posedge mclk);
        hsIn <= 5'h1F;
        wait_cyc(2);
        chk(16'(hsCommand), 16'h001F);
        for (int k = 0; k < 4; k++) begin
            set_block(k, 1'b1);
            chk(16'(hsCommand), 16'h0000);
            chk(16'(deviceOff), 16'(k == 3));
            set_block(k, 1'b0);
            chk(16'(hsCommand), 16'h001F);
        end
        $display("test permits done");
        @(posedge mclk);
        groundLost <= 1'b1;
        wait_cyc(7);
        chk(16'(gateSupplyUndervoltage), 16'h0000);
        wait_cyc(1);
        chk(16'(gateSupplyUndervoltage), 16'h0001);
        wait_cyc(1);
        chk(16'(hsCommand), 16'h0000);
        rd_reg(fsm_pkg::DRIVER_FAULT_STATUS_ADDR, rd);
        chk(16'(rd[fsm_pkg::STS_GATE_UV_BIT]), 16'h0001);
        @(posedge mclk);
        groundLost <= 1'b0;
        wait_cyc(3);
        chk(16'(hsCommand), 16'h001F);
        $display("test ground loss done");
        @(posedge mclk);
        overTemp <= 1'b1;
        #1;
        chk(16'(interruptRequest_n), 16'h0000);
        @(posedge mclk);
        overTemp <= 1'b0;
        wait_cyc(3);
        chk(16'(driverEnable), 16'h0000);
        chk(16'(hsCommand), 16'h0000);
        rd_reg(fsm_pkg::DRIVER_FAULT_STATUS_ADDR, rd);
        chk(16'(rd[1:0]), 16'h0001);
        rd_reg(fsm_pkg::DRIVER_FAULT_STATUS_ADDR, rd);
        chk(16'(rd[fsm_pkg::STS_OVERHEAT_BIT]), 16'h0000);
        chk(16'(interruptRequest_n), 16'h0001);
        @(posedge mclk);
        rearm <= 1'b1;
        @(posedge mclk);
        rearm <= 1'b0;
        wait_cyc(2);
        chk(16'(hsCommand), 16'h001F);
        rd_reg(fsm_pkg::DRIVER_FAULT_STATUS_ADDR, rd);
        chk(16'(rd[fsm_pkg::STS_DRIVER_ENABLE_BIT]), 16'h0001);
        $display("test overheat done");
        wr(fsm_pkg::DRIVER_CONFIGURATION_ADDR, 16'h0000);
        @(posedge mclk);
        overTemp <= 1'b1;
        hsIn <= 5'h05;
        wait_cyc(2);
        chk(16'(interruptRequest_n), 16'h0001);
        chk(16'(hsCommand), 16'h0005);
        rd_reg(fsm_pkg::DRIVER_FAULT_STATUS_ADDR, rd);
        chk(16'(rd[1:0]), 16'h0003);
        @(posedge mclk);
        overTemp <= 1'b0;
        wait_cyc(1);
        rd_reg(fsm_pkg::DRIVER_FAULT_STATUS_ADDR, rd);
        chk(16'(rd[fsm_pkg::STS_OVERHEAT_BIT]), 16'h0001);
        rd_reg(fsm_pkg::DRIVER_FAULT_STATUS_ADDR, rd);
        chk(16'(rd[fsm_pkg::STS_OVERHEAT_BIT]), 16'h0000);
        $display("test interrupt mask done");
        print_verdict();
    end

    initial begin
        repeat (2000) @(posedge mclk);
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
